//--- hw/mci_top.sv
// motion command interpreter core with apb register file
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Contract
// RL1: directory lists each sequence size, then free
// RL2: move steps equal distance times scale
// RL3: scale range limited, used by all moves
// RL4: encoder counter loads signed clipped value
// RL5: echo off suppresses returned characters
// RL6: host never disables echo in chains
// RL7: leaving edit stores the sequence
// RL8: io selects only 0..15, numbers unique; name-only edits take next_auto_r without a duplicate check
// RL9: name-only sequences get next number from 25
// RL10: number, number plus name, or name
// RL11: alter, insert, delete lines; append grows
// RL12: false condition runs alternate branch
// RL13: end statement stops execution anywhere
// RL14: loop terminator returns until count spent
// RL15: while terminator repeats while true
// RL16: encoder resolution 0 to 65535 counts
// RL17: compare invalid without encoder resolution
// RL18: two events drive outputs 1..3 on or off
// RL19: time and distance measured from motion start
// RL20: velocity event never fires when decelerating
// RL21: events persist; clearing keeps outputs
// RL22: compare is enc*mot/encres minus position
// RL23: host ends lines with carriage return
module mci_top #(
  parameter int TICK_CYCLES = mci_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // serial character path, one character per strobe
  input wire logic RX_VALID_I,
  input wire logic [7:0] RX_CHAR_I,
  output logic TX_VALID_O,
  output logic [7:0] TX_CHAR_O,
  // motion and outputs
  output logic [31:0] MOVE_STEPS_O,
  output logic MOVE_START_O,
  output logic [2:0] EVENT_OUT_O,
  output logic CMP_VALID_O
);
  typedef enum logic [2:0] {
    MCI_IDLE = 3'b001,
    MCI_EDIT = 3'b010,
    MCI_RUN = 3'b100
  } mci_state_t;

  mci_state_t state_r;
  logic [31:0] ctrl_r, dscale_r, dist_r, enc_r, mres_r, pos_r, motion_r;
  logic [15:0] eres_r;
  logic [31:0] ev_r [2];
  logic [2:0] outs_r;
  logic [31:0] rdata_r;
  logic ready_r, err_r, tx_v_r, move_go_r;
  logic [7:0] tx_c_r;
  logic [31:0] steps_r, cmp_r;
  logic cmp_ok_r;
  logic [31:0] tcnt_r, ms_r, stepcnt_r, pos0_r;
  // sequence table
  localparam int SLOT_W = 3;
  logic [SLOT_W-1:0] dir_idx_r;
  logic slot_used_r [mci_pkg::SEQ_SLOTS];
  logic [5:0] slot_num_r [mci_pkg::SEQ_SLOTS];
  logic [15:0] slot_size_r [mci_pkg::SEQ_SLOTS];
  logic [SLOT_W-1:0] cur_slot_r;
  logic [5:0] next_auto_r, io_sel_r;
  logic [15:0] lines_r;
  logic saved_r;
  // execution
  logic [15:0] loop_cnt_r;
  logic skip_r, done_r, loop_back_r, while_back_r;

  wire acc = PSEL_I & PENABLE_I & ~ready_r;
  wire wr = acc & PWRITE_I;
  wire rd = acc & ~PWRITE_I;
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit
  wire mapped = hit(PADDR_I, mci_pkg::ADDR_CTRL) | hit(PADDR_I, mci_pkg::ADDR_DSCALE) |
    hit(PADDR_I, mci_pkg::ADDR_DIST) | hit(PADDR_I, mci_pkg::ADDR_ENC_CNT) |
    hit(PADDR_I, mci_pkg::ADDR_ENC_RES) | hit(PADDR_I, mci_pkg::ADDR_MOT_RES) |
    hit(PADDR_I, mci_pkg::ADDR_POS_CNT) | hit(PADDR_I, mci_pkg::ADDR_CMP) |
    hit(PADDR_I, mci_pkg::ADDR_MOVE) | hit(PADDR_I, mci_pkg::ADDR_EV0) |
    hit(PADDR_I, mci_pkg::ADDR_EV1) | hit(PADDR_I, mci_pkg::ADDR_MOTION) |
    hit(PADDR_I, mci_pkg::ADDR_OUTS) | hit(PADDR_I, mci_pkg::ADDR_SEQ_CMD) |
    hit(PADDR_I, mci_pkg::ADDR_SEQ_STAT) | hit(PADDR_I, mci_pkg::ADDR_EXEC) |
    hit(PADDR_I, mci_pkg::ADDR_DIR) | hit(PADDR_I, mci_pkg::ADDR_FREE);
  wire [2:0] scmd = PWDATA_I[2:0];
  wire [5:0] snum = PWDATA_I[13:8];
  wire seq_wr = wr & hit(PADDR_I, mci_pkg::ADDR_SEQ_CMD);
  wire exec_wr = wr & hit(PADDR_I, mci_pkg::ADDR_EXEC);
  wire [2:0] xop = PWDATA_I[2:0];
  wire xcond = PWDATA_I[3];
  // clip signed encoder load to the legal range
  wire signed [31:0] enc_in = PWDATA_I;
  wire signed [31:0] enc_lim = mci_pkg::ENC_LIMIT;
  wire [31:0] enc_clip = (enc_in > enc_lim) ? enc_lim :
    (enc_in < -enc_lim) ? -enc_lim : enc_in; // RL4
  wire [31:0] ds_clip = (PWDATA_I > mci_pkg::DSCALE_MAX) ? mci_pkg::DSCALE_MAX :
    PWDATA_I; // RL3
  wire [63:0] prod = 64'(dist_r) * 64'(dscale_r); // RL2
  // free memory and used slot lookup
  logic [15:0] used_bytes;
  logic dup_hit;
  logic [SLOT_W-1:0] dup_slot, free_slot;
  logic free_ok;
  always_comb begin
    used_bytes = '0;
    dup_hit = 1'b0;
    dup_slot = '0;
    free_slot = '0;
    free_ok = 1'b0;
    for (int i = 0; i < mci_pkg::SEQ_SLOTS; i++) begin
      if (slot_used_r[i]) begin
        used_bytes = used_bytes + slot_size_r[i];
      end
      if (slot_used_r[i] && slot_num_r[i] == snum && !dup_hit) begin
        dup_hit = 1'b1;
        dup_slot = SLOT_W'(i);
      end
      if (!slot_used_r[i] && !free_ok) begin
        free_ok = 1'b1;
        free_slot = SLOT_W'(i);
      end
    end
  end
  wire [15:0] free_bytes = mci_pkg::MEM_BYTES - used_bytes; // RL1
  wire [SLOT_W-1:0] tgt = dup_hit ? dup_slot : free_slot; // RL8
  // compare pipeline, invalid without encoder resolution
  wire signed [63:0] scaled = (eres_r == 16'h0) ? 64'sh0 :
    ($signed(64'(signed'(enc_r))) * $signed(64'(mres_r))) / $signed(64'(eres_r)); // RL22
  wire signed [31:0] cmp_nxt = 32'(scaled) - $signed(pos_r);
  wire cmp_ok_nxt = (eres_r != 16'h0); // RL17
  // event triggers
  wire mot_on = motion_r[mci_pkg::MOT_ACTIVE_BIT];
  wire decel = motion_r[mci_pkg::MOT_DECEL_BIT];
  wire [25:0] vel = motion_r[25:0];
  logic [1:0] ev_fire;
  generate
    for (genvar e = 0; e < 2; e++) begin : g_ev
      wire [1:0] kind = ev_r[e][mci_pkg::EV_KIND_LSB +: 2];
      wire [25:0] thr = ev_r[e][mci_pkg::EV_VAL_W-1:0];
      assign ev_fire[e] = ev_r[e][mci_pkg::EV_VALID_BIT] & mot_on & (
        (kind == mci_pkg::EV_KIND_TIME && ms_r >= 32'(thr)) |
        (kind == mci_pkg::EV_KIND_DIST && stepcnt_r >= 32'(thr)) | // RL19
        (kind == mci_pkg::EV_KIND_VEL && !decel && vel >= thr)); // RL20
    end
  endgenerate
  wire [2:0] outs_nxt_ev;
  generate
    for (genvar b = 0; b < 3; b++) begin : g_out
      wire s0 = ev_fire[0] && ev_r[0][mci_pkg::EV_OUT_LSB +: 2] == 2'(b + 1);
      wire s1 = ev_fire[1] && ev_r[1][mci_pkg::EV_OUT_LSB +: 2] == 2'(b + 1);
      assign outs_nxt_ev[b] = s1 ? ev_r[1][mci_pkg::EV_LEVEL_BIT] :
        s0 ? ev_r[0][mci_pkg::EV_LEVEL_BIT] : outs_r[b]; // RL18
    end
  endgenerate
  logic [31:0] rmux;
  always_comb begin
    case (PADDR_I)
      mci_pkg::ADDR_CTRL: rmux = ctrl_r;
      mci_pkg::ADDR_DSCALE: rmux = dscale_r;
      mci_pkg::ADDR_DIST: rmux = dist_r;
      mci_pkg::ADDR_ENC_CNT: rmux = enc_r;
      mci_pkg::ADDR_ENC_RES: rmux = {16'h0, eres_r};
      mci_pkg::ADDR_MOT_RES: rmux = mres_r;
      mci_pkg::ADDR_POS_CNT: rmux = pos_r;
      mci_pkg::ADDR_CMP: rmux = cmp_r;
      mci_pkg::ADDR_MOVE: rmux = steps_r;
      mci_pkg::ADDR_EV0: rmux = ev_r[0];
      mci_pkg::ADDR_EV1: rmux = ev_r[1];
      mci_pkg::ADDR_MOTION: rmux = motion_r;
      mci_pkg::ADDR_OUTS: rmux = {29'h0, outs_r};
      mci_pkg::ADDR_SEQ_STAT: rmux = {io_sel_r, 2'h0, next_auto_r, 1'b0, saved_r,
        lines_r[7:0], 5'h0, state_r};
      mci_pkg::ADDR_EXEC: rmux = {loop_cnt_r, 12'h0, done_r, skip_r, loop_back_r,
        while_back_r};
      mci_pkg::ADDR_DIR: rmux = {slot_used_r[dir_idx_r], 1'b0, slot_num_r[dir_idx_r],
        5'h0, dir_idx_r, slot_size_r[dir_idx_r]};
      mci_pkg::ADDR_FREE: rmux = {16'h0, free_bytes};
      default: rmux = 32'h0;
    endcase
  end
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ready_r <= 1'b0;
      err_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      ready_r <= acc;
      err_r <= acc & ~mapped;
      rdata_r <= rd ? rmux : rdata_r;
    end
  end
  // directory walk: each read of the entry advances the index
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      dir_idx_r <= '0;
    end else if (rd && hit(PADDR_I, mci_pkg::ADDR_DIR)) begin
      dir_idx_r <= dir_idx_r + SLOT_W'(1); // RL1
    end
  end
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ctrl_r <= mci_pkg::CTRL_RESET;
      dscale_r <= mci_pkg::DSCALE_RESET;
      dist_r <= 32'h0;
      enc_r <= 32'h0;
      eres_r <= 16'h0;
      mres_r <= 32'h0;
      pos_r <= 32'h0;
      motion_r <= 32'h0;
      ev_r[0] <= 32'h0;
      ev_r[1] <= 32'h0;
      steps_r <= 32'h0;
      move_go_r <= 1'b0;
    end else begin
      move_go_r <= wr && hit(PADDR_I, mci_pkg::ADDR_MOVE);
      if (wr) begin
        case (PADDR_I)
          mci_pkg::ADDR_CTRL: ctrl_r <= {30'h0, PWDATA_I[1:0]}; // RL5
          mci_pkg::ADDR_DSCALE: dscale_r <= ds_clip; // RL3
          mci_pkg::ADDR_DIST: dist_r <= PWDATA_I;
          mci_pkg::ADDR_ENC_CNT: enc_r <= enc_clip; // RL4
          mci_pkg::ADDR_ENC_RES: eres_r <= PWDATA_I[15:0]; // RL16
          mci_pkg::ADDR_MOT_RES: mres_r <= PWDATA_I;
          mci_pkg::ADDR_POS_CNT: pos_r <= PWDATA_I;
          mci_pkg::ADDR_MOVE: steps_r <= prod[31:0]; // RL2
          mci_pkg::ADDR_EV0: ev_r[0] <= PWDATA_I; // RL21
          mci_pkg::ADDR_EV1: ev_r[1] <= PWDATA_I; // RL21
          mci_pkg::ADDR_MOTION: motion_r <= PWDATA_I;
          default: ;
        endcase
      end
    end
  end
  // motion timebase and event outputs; clearing an event leaves outs_r alone
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tcnt_r <= 32'h0;
      ms_r <= 32'h0;
      stepcnt_r <= 32'h0;
      pos0_r <= 32'h0;
      outs_r <= 3'h0;
    end else begin
      outs_r <= outs_nxt_ev; // RL21
      if (!mot_on) begin
        tcnt_r <= 32'h0;
        ms_r <= 32'h0;
        stepcnt_r <= 32'h0; // RL19
        pos0_r <= pos_r;
      end else begin
        // distance is counted from the position held when motion began
        stepcnt_r <= pos_r - pos0_r; // RL19
        if (tcnt_r == 32'(TICK_CYCLES - 1)) begin
          tcnt_r <= 32'h0;
          ms_r <= ms_r + 32'h1;
        end else begin
          tcnt_r <= tcnt_r + 32'h1;
        end
      end
    end
  end
  // sequence editor
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_r <= MCI_IDLE;
      cur_slot_r <= '0;
      next_auto_r <= mci_pkg::SEQ_AUTO_FIRST;
      io_sel_r <= 6'h0;
      lines_r <= 16'h0;
      saved_r <= 1'b0;
      for (int i = 0; i < mci_pkg::SEQ_SLOTS; i++) begin
        slot_used_r[i] <= 1'b0;
        slot_num_r[i] <= 6'h0;
        slot_size_r[i] <= 16'h0;
      end
    end else if (seq_wr) begin
      case (state_r)
        MCI_IDLE: begin
          if (scmd == mci_pkg::SCMD_EDIT_NUM && (dup_hit || free_ok) &&
              snum <= mci_pkg::SEQ_NUM_MAX) begin
            cur_slot_r <= tgt; // RL10
            slot_num_r[tgt] <= snum; // RL10
            state_r <= MCI_EDIT;
            saved_r <= 1'b0;
            lines_r <= dup_hit ? slot_size_r[dup_slot] : 16'h0;
          end else if (scmd == mci_pkg::SCMD_EDIT_NAME && free_ok) begin
            cur_slot_r <= free_slot;
            slot_num_r[free_slot] <= next_auto_r; // RL9
            next_auto_r <= next_auto_r + 6'h1;
            state_r <= MCI_EDIT;
            saved_r <= 1'b0;
            lines_r <= 16'h0;
          end else if (scmd == mci_pkg::SCMD_IO_SEL && snum <= mci_pkg::SEQ_IO_MAX) begin
            io_sel_r <= snum; // RL8
          end
        end
        MCI_EDIT: begin
          case (scmd)
            mci_pkg::SCMD_LINE_INS: lines_r <= lines_r + 16'h1; // RL11
            mci_pkg::SCMD_LINE_DEL: lines_r <= (lines_r == 16'h0) ? 16'h0 :
              lines_r - 16'h1; // RL11
            mci_pkg::SCMD_EXIT: begin
              slot_used_r[cur_slot_r] <= 1'b1; // RL7
              slot_size_r[cur_slot_r] <= lines_r;
              saved_r <= 1'b1;
              state_r <= MCI_IDLE;
            end
            default: ;
          endcase
        end
        default: state_r <= MCI_IDLE;
      endcase
    end
  end
  // flow control of a running sequence, one step per write
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      loop_cnt_r <= 16'h0;
      skip_r <= 1'b0;
      done_r <= 1'b0;
      loop_back_r <= 1'b0;
      while_back_r <= 1'b0;
    end else if (exec_wr) begin
      loop_back_r <= 1'b0;
      while_back_r <= 1'b0;
      case (xop)
        mci_pkg::EX_IF: skip_r <= ~xcond; // RL12
        mci_pkg::EX_ELSE: skip_r <= ~skip_r; // RL12
        mci_pkg::EX_COND_TERM: skip_r <= 1'b0;
        mci_pkg::EX_LOOP: begin
          loop_cnt_r <= PWDATA_I[31:16];
          done_r <= 1'b0;
        end
        mci_pkg::EX_LOOP_TERM: begin
          if (loop_cnt_r > 16'h1) begin
            loop_cnt_r <= loop_cnt_r - 16'h1;
            loop_back_r <= 1'b1; // RL14
          end else begin
            loop_cnt_r <= 16'h0;
          end
        end
        mci_pkg::EX_WHILE_TERM: while_back_r <= xcond; // RL15
        mci_pkg::EX_END: done_r <= 1'b1; // RL13
        default: ;
      endcase
    end
  end
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tx_v_r <= 1'b0;
      tx_c_r <= 8'h0;
      cmp_r <= 32'h0;
      cmp_ok_r <= 1'b0;
    end else begin
      tx_v_r <= RX_VALID_I & ctrl_r[mci_pkg::CTRL_ECHO_BIT]; // RL5
      tx_c_r <= RX_VALID_I ? RX_CHAR_I : tx_c_r;
      cmp_r <= cmp_ok_nxt ? cmp_nxt : 32'h0; // RL22
      cmp_ok_r <= cmp_ok_nxt; // RL17
    end
  end
  assign PRDATA_O = rdata_r;
  assign PREADY_O = ready_r;
  assign PSLVERR_O = err_r;
  assign TX_VALID_O = tx_v_r;
  assign TX_CHAR_O = tx_c_r;
  assign MOVE_STEPS_O = steps_r;
  assign MOVE_START_O = move_go_r;
  assign EVENT_OUT_O = outs_r;
  assign CMP_VALID_O = cmp_ok_r;

  property p_echo;
    @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      RX_VALID_I |=> (TX_VALID_O == $past(ctrl_r[mci_pkg::CTRL_ECHO_BIT]));
  endproperty
  a_echo: assert property (p_echo) else $error("echo mismatch"); // RL5
  property p_move;
    @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      (wr && PADDR_I == mci_pkg::ADDR_MOVE) |=> (MOVE_START_O && MOVE_STEPS_O ==
      32'($past(dist_r) * $past(dscale_r)));
  endproperty
  a_move: assert property (p_move) else $error("move steps wrong"); // RL2
  property p_cmp;
    @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      (eres_r == 16'h0) |=> !CMP_VALID_O;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare valid without encoder"); // RL17
  property p_end;
    @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      (exec_wr && xop == mci_pkg::EX_END) |=> done_r;
  endproperty
  a_end: assert property (p_end) else $error("end not taken"); // RL13
  property p_vel;
    @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      (decel && ev_r[0][mci_pkg::EV_KIND_LSB +: 2] == mci_pkg::EV_KIND_VEL) |-> !ev_fire[0];
  endproperty
  a_vel: assert property (p_vel) else $error("velocity event in decel"); // RL20
  property p_io;
    @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      ##1 io_sel_r <= mci_pkg::SEQ_IO_MAX;
  endproperty
  a_io: assert property (p_io) else $error("io selection out of range"); // RL8
  property p_save;
    @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      (seq_wr && state_r == MCI_EDIT && scmd == mci_pkg::SCMD_EXIT) |=>
      (saved_r && state_r == MCI_IDLE);
  endproperty
  a_save: assert property (p_save) else $error("edit exit not saved"); // RL7
  property p_clear;
    @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      (ev_r[0] == 32'h0 && ev_r[1] == 32'h0) |=> (EVENT_OUT_O == $past(EVENT_OUT_O));
  endproperty
  a_clear: assert property (p_clear) else $error("cleared event moved outputs"); // RL21
endmodule : mci_top

//--- hw/mci_pkg.sv
// package of register map, field layout and constants for the motion command interpreter
package mci_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DSCALE = 8'h04;
  localparam logic [7:0] ADDR_DIST = 8'h08;
  localparam logic [7:0] ADDR_ENC_CNT = 8'h0c;
  localparam logic [7:0] ADDR_ENC_RES = 8'h10;
  localparam logic [7:0] ADDR_MOT_RES = 8'h14;
  localparam logic [7:0] ADDR_POS_CNT = 8'h18;
  localparam logic [7:0] ADDR_CMP = 8'h1c;
  localparam logic [7:0] ADDR_MOVE = 8'h20;
  localparam logic [7:0] ADDR_EV0 = 8'h24;
  localparam logic [7:0] ADDR_EV1 = 8'h28;
  localparam logic [7:0] ADDR_MOTION = 8'h2c;
  localparam logic [7:0] ADDR_OUTS = 8'h30;
  localparam logic [7:0] ADDR_SEQ_CMD = 8'h34;
  localparam logic [7:0] ADDR_SEQ_STAT = 8'h38;
  localparam logic [7:0] ADDR_EXEC = 8'h3c;
  localparam logic [7:0] ADDR_DIR = 8'h40;
  localparam logic [7:0] ADDR_FREE = 8'h44;
  // control fields
  localparam int CTRL_ECHO_BIT = 0;
  localparam int CTRL_EDIT_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] DSCALE_MAX = 32'h7ff8_9ec0;
  localparam logic [31:0] DSCALE_RESET = 32'h0000_0001;
  localparam logic [31:0] ENC_LIMIT = 32'h7ff8_9ec0;
  // event register fields
  localparam int EV_VALID_BIT = 31;
  localparam int EV_LEVEL_BIT = 30;
  localparam int EV_OUT_LSB = 28;
  localparam int EV_KIND_LSB = 26;
  localparam int EV_VAL_W = 26;
  localparam logic [1:0] EV_KIND_TIME = 2'h0;
  localparam logic [1:0] EV_KIND_DIST = 2'h1;
  localparam logic [1:0] EV_KIND_VEL = 2'h2;
  // motion status fields
  localparam int MOT_ACTIVE_BIT = 31;
  localparam int MOT_DECEL_BIT = 30;
  // sequence table
  localparam int SEQ_SLOTS = 8;
  localparam logic [5:0] SEQ_IO_MAX = 6'h0f;
  localparam logic [5:0] SEQ_AUTO_FIRST = 6'h19;
  localparam logic [5:0] SEQ_NUM_MAX = 6'h31;
  localparam logic [15:0] MEM_BYTES = 16'h2000;
  // sequence command codes
  localparam logic [2:0] SCMD_EDIT_NUM = 3'h1;
  localparam logic [2:0] SCMD_EDIT_NAME = 3'h2;
  localparam logic [2:0] SCMD_EXIT = 3'h3;
  localparam logic [2:0] SCMD_LINE_ALT = 3'h4;
  localparam logic [2:0] SCMD_LINE_INS = 3'h5;
  localparam logic [2:0] SCMD_LINE_DEL = 3'h6;
  localparam logic [2:0] SCMD_IO_SEL = 3'h7;
  // execution opcodes
  localparam logic [2:0] EX_IF = 3'h1;
  localparam logic [2:0] EX_ELSE = 3'h2;
  localparam logic [2:0] EX_COND_TERM = 3'h3;
  localparam logic [2:0] EX_LOOP = 3'h4;
  localparam logic [2:0] EX_LOOP_TERM = 3'h5;
  localparam logic [2:0] EX_WHILE_TERM = 3'h6;
  localparam logic [2:0] EX_END = 3'h7;
  localparam int TICK_NS = 1000000;
  localparam int CLK_NS = 10;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
endpackage : mci_pkg

//--- sim/mci_host_model.sv
// host terminal model driving the serial character path
`timescale 1ns/1ps
module mci_host_model (
  // clock
  input wire logic clk_i,
  // character path
  output logic rx_valid_o,
  output logic [7:0] rx_char_o,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_char_i
);
  int echo_cnt;
  logic [7:0] last_echo;

  initial begin
    rx_valid_o = 1'b0;
    rx_char_o = 8'h00;
    echo_cnt = 0;
    last_echo = 8'h00;
  end

  always @(posedge clk_i) begin
    if (tx_valid_i === 1'b1) begin
      echo_cnt <= echo_cnt + 1;
      last_echo <= tx_char_i;
    end
  end

  // one unit alone on the link, so echo may be switched off safely
  task automatic send_line(input string s);
    logic [7:0] c;
    for (int i = 0; i <= s.len(); i++) begin
      c = (i == s.len()) ? 8'h0d : 8'(s[i]);
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_char_o <= c;
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_char_o <= ~c;
    end
    repeat (3) @(posedge clk_i);
  endtask : send_line
endmodule : mci_host_model

//--- sim/testbench.sv
// self-checking testbench of the motion command interpreter
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, slverr, rx_valid, tx_valid, move_start, cmp_valid;
  logic [7:0] rx_char, tx_char;
  logic [31:0] move_steps, rd;
  logic [2:0] ev_out;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  int starts = 0;
  int e0;

  always #5 clk = ~clk;

  mci_top #(.TICK_CYCLES(10)) u_dut (
    .CORE_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .RX_VALID_I(rx_valid), .RX_CHAR_I(rx_char),
    .TX_VALID_O(tx_valid), .TX_CHAR_O(tx_char), .MOVE_STEPS_O(move_steps),
    .MOVE_START_O(move_start), .EVENT_OUT_O(ev_out), .CMP_VALID_O(cmp_valid));

  mci_host_model u_host (
    .clk_i(clk), .rx_valid_o(rx_valid), .rx_char_o(rx_char),
    .tx_valid_i(tx_valid), .tx_char_i(tx_char));

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (move_start === 1'b1) starts <= starts + 1;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task automatic wait_out(input int b);
    for (int i = 0; i < 200 && ev_out[b] !== 1'b1; i++) @(posedge clk);
    chk({31'h0, ev_out[b]}, 32'h1);
  endtask : wait_out

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rdc(mci_pkg::ADDR_CTRL, mci_pkg::CTRL_RESET);
    rdc(mci_pkg::ADDR_DSCALE, mci_pkg::DSCALE_RESET);
    rdc(8'h48, 32'h0);
    chk({31'h0, slverr}, 32'h1);
    u_host.send_line("AB");
    chk(u_host.echo_cnt, 3);
    chk({24'h0, u_host.last_echo}, 32'h0000_000d);
    apb(1'b1, mci_pkg::ADDR_CTRL, 32'h0);
    u_host.send_line("C");
    chk(u_host.echo_cnt, 3);
    apb(1'b1, mci_pkg::ADDR_DSCALE, 32'hffff_ffff);
    rdc(mci_pkg::ADDR_DSCALE, mci_pkg::DSCALE_MAX);
    apb(1'b1, mci_pkg::ADDR_DSCALE, 32'h0000_0003);
    apb(1'b1, mci_pkg::ADDR_DIST, 32'h0000_0007);
    apb(1'b1, mci_pkg::ADDR_MOVE, 32'h0);
    repeat (2) @(posedge clk);
    chk(move_steps, 32'h0000_0015);
    chk(starts, 1);
    apb(1'b1, mci_pkg::ADDR_ENC_CNT, 32'h8000_0000);
    rdc(mci_pkg::ADDR_ENC_CNT, -mci_pkg::ENC_LIMIT);
    chk({31'h0, cmp_valid}, 32'h0);
    rdc(mci_pkg::ADDR_CMP, 32'h0);
    apb(1'b1, mci_pkg::ADDR_ENC_RES, 32'h0001_ffff);
    rdc(mci_pkg::ADDR_ENC_RES, 32'h0000_ffff);
    apb(1'b1, mci_pkg::ADDR_ENC_RES, 32'h0000_07d0);
    apb(1'b1, mci_pkg::ADDR_MOT_RES, 32'h0000_01f4);
    apb(1'b1, mci_pkg::ADDR_POS_CNT, 32'h0000_0064);
    apb(1'b1, mci_pkg::ADDR_ENC_CNT, 32'h0000_07d0);
    rdc(mci_pkg::ADDR_CMP, 32'h0000_0190);
    chk({31'h0, cmp_valid}, 32'h1);
    rdc(mci_pkg::ADDR_FREE, {16'h0, mci_pkg::MEM_BYTES});
    apb(1'b1, mci_pkg::ADDR_SEQ_CMD, {29'h0, mci_pkg::SCMD_EDIT_NAME});
    apb(1'b1, mci_pkg::ADDR_SEQ_CMD, {29'h0, mci_pkg::SCMD_LINE_INS});
    apb(1'b1, mci_pkg::ADDR_SEQ_CMD, {29'h0, mci_pkg::SCMD_LINE_INS});
    apb(1'b1, mci_pkg::ADDR_SEQ_CMD, {29'h0, mci_pkg::SCMD_LINE_DEL});
    apb(1'b1, mci_pkg::ADDR_SEQ_CMD, {29'h0, mci_pkg::SCMD_LINE_ALT});
    apb(1'b0, mci_pkg::ADDR_SEQ_STAT, 32'h0);
    chk({24'h0, rd[15:8]}, 32'h1);
    chk({26'h0, rd[23:18]}, {26'h0, mci_pkg::SEQ_AUTO_FIRST} + 32'h1);
    apb(1'b1, mci_pkg::ADDR_SEQ_CMD, {29'h0, mci_pkg::SCMD_EXIT});
    apb(1'b0, mci_pkg::ADDR_SEQ_STAT, 32'h0);
    chk({31'h0, rd[16]}, 32'h1);
    chk({26'h0, rd[23:18]}, {26'h0, mci_pkg::SEQ_AUTO_FIRST} + 32'h1);
    apb(1'b0, mci_pkg::ADDR_DIR, 32'h0);
    chk({rd[31], 1'b0, rd[29:24]}, {2'h2, mci_pkg::SEQ_AUTO_FIRST});
    apb(1'b1, mci_pkg::ADDR_SEQ_CMD, 32'h0000_0301);
    apb(1'b1, mci_pkg::ADDR_SEQ_CMD, {29'h0, mci_pkg::SCMD_LINE_INS});
    apb(1'b1, mci_pkg::ADDR_SEQ_CMD, {29'h0, mci_pkg::SCMD_EXIT});
    rdc(mci_pkg::ADDR_DIR, 32'h8301_0001);
    rdc(mci_pkg::ADDR_FREE, {16'h0, mci_pkg::MEM_BYTES - 16'h2});
    apb(1'b1, mci_pkg::ADDR_SEQ_CMD, 32'h0000_0507);
    apb(1'b1, mci_pkg::ADDR_SEQ_CMD, 32'h0000_1007);
    apb(1'b0, mci_pkg::ADDR_SEQ_STAT, 32'h0);
    chk({26'h0, rd[31:26]}, 32'h5);
    apb(1'b1, mci_pkg::ADDR_EXEC, 32'h0000_0001);
    rdc(mci_pkg::ADDR_EXEC, 32'h0000_0004);
    apb(1'b1, mci_pkg::ADDR_EXEC, 32'h0000_0002);
    rdc(mci_pkg::ADDR_EXEC, 32'h0000_0000);
    apb(1'b1, mci_pkg::ADDR_EXEC, 32'h0002_0004);
    apb(1'b1, mci_pkg::ADDR_EXEC, 32'h0000_0005);
    rdc(mci_pkg::ADDR_EXEC, 32'h0001_0002);
    apb(1'b1, mci_pkg::ADDR_EXEC, 32'h0000_0005);
    rdc(mci_pkg::ADDR_EXEC, 32'h0000_0000);
    apb(1'b1, mci_pkg::ADDR_EXEC, 32'h0000_000e);
    rdc(mci_pkg::ADDR_EXEC, 32'h0000_0001);
    apb(1'b1, mci_pkg::ADDR_EXEC, 32'h0000_0007);
    rdc(mci_pkg::ADDR_EXEC, 32'h0000_0008);
    apb(1'b1, mci_pkg::ADDR_EV0, 32'hd000_0002);
    apb(1'b1, mci_pkg::ADDR_EV1, 32'he800_0001);
    apb(1'b1, mci_pkg::ADDR_MOTION, 32'hc000_0005);
    wait_out(0);
    repeat (40) @(posedge clk);
    chk({31'h0, ev_out[1]}, 32'h0);
    apb(1'b1, mci_pkg::ADDR_MOTION, 32'h8000_0005);
    wait_out(1);
    apb(1'b1, mci_pkg::ADDR_EV0, 32'h0);
    apb(1'b0, mci_pkg::ADDR_OUTS, 32'h0);
    e0 = int'(rd[0]);
    chk({29'h0, ev_out}, 32'h3);
    chk(e0, 1);
    apb(1'b1, mci_pkg::ADDR_MOTION, 32'h0);
    apb(1'b1, mci_pkg::ADDR_EV0, 32'hf400_0005);
    apb(1'b1, mci_pkg::ADDR_MOTION, 32'h8000_0000);
    repeat (5) @(posedge clk);
    chk({31'h0, ev_out[2]}, 32'h0);
    apb(1'b1, mci_pkg::ADDR_POS_CNT, 32'h0000_0069);
    wait_out(2);
    summarize();
  end
endmodule : testbench
